// [drs_ctrl_model.sv]
// controller stand-in: makes the link clock, drives clock enable, command, termination and write-error pins
// assumes the bench paces commands by the refresh cycle time and calls set_run only around self-refresh
`timescale 1ns/1ps
module drs_ctrl_model (
  output logic link_clk,
  output logic cke,
  output drs_pkg::drs_cmd_s cmd,
  output logic termination_control,
  output logic wr_timing_err,
  output logic [drs_pkg::ADDR_W-1:0] wr_addr
);
  logic raw_clk = 1'b0;
  logic run_req = 1'b1;
  logic run_q = 1'b1;
  // half-nanosecond offset keeps link edges from ever meeting core edges
  initial begin
    #0.5;
    forever #3 raw_clk = ~raw_clk;
  end
  // gate on the low phase so a stop never clips a pulse
  always @(negedge raw_clk) run_q <= run_req;
  assign link_clk = raw_clk & run_q;
  initial begin
    cke = 1'b1;
    cmd = 4'hf;
    termination_control = 1'b0;
    wr_timing_err = 1'b0;
    wr_addr = '0;
  end
  // one command per edge; idle commands between are the caller's job
  task send(input logic ck, input logic [3:0] c, input logic t);
    @(posedge link_clk);
    #1;
    cke = ck;
    cmd = c;
    termination_control = t;
  endtask
  // flag one write as violating its strobe timing; address is not held afterwards
  task werr(input logic [drs_pkg::ADDR_W-1:0] a);
    @(posedge link_clk);
    #1;
    wr_timing_err = 1'b1;
    wr_addr = a;
    @(posedge link_clk);
    #1;
    wr_timing_err = 1'b0;
    wr_addr = ~a;
  endtask
  task set_run(input logic b);
    run_req = b;
    repeat (3) @(negedge raw_clk);
  endtask
endmodule // drs_ctrl_model

// [drs_pkg.sv]
// constants, types and timing counts for the refresh and self-refresh block
// assumes a 20 MHz core clock; the link clock is the memory command clock
package drs_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // refresh_cycle_time, a least time: round up
  localparam int unsigned REFRESH_CYCLE_TIME_NS = 160;
  localparam int unsigned RFC_CYC_RAW = (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RFC_CYC = (RFC_CYC_RAW < 1) ? 1 : RFC_CYC_RAW;
  // avg_refresh_interval, a longest time for the built-in timer: round down
  localparam int unsigned AVG_REFRESH_INTERVAL_NS = 8000;
  localparam int unsigned REFI_CYC_RAW = AVG_REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int unsigned REFI_CYC = (REFI_CYC_RAW < 1) ? 1 : REFI_CYC_RAW;
  // write latency in link clocks; termination_latency is two less
  localparam int unsigned WRITE_LATENCY = 5;
  localparam int unsigned TERM_LAT_OFFSET = 2;
  localparam int unsigned ROW_W = 14;
  localparam int unsigned ADDR_W = 14;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } drs_cmd_s;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
  } drs_poison_s;

  typedef enum logic [1:0] {
    DRS_L_RUN = 2'b01,
    DRS_L_SR = 2'b10
  } drs_link_e;

  typedef enum logic [1:0] {
    DRS_C_NORM = 2'b01,
    DRS_C_SR = 2'b10
  } drs_core_e;
endpackage

// [drs_refresh_top.sv]
// refresh and self-refresh control: command decode on the link clock, refresh engine on clk
// assumes the controller keeps its own timing; link clock may stop only while in self-refresh
`timescale 1ns/1ps
// Function
// - setup or hold failure on a write only flags that write's address, nothing hangs.
// - strobe width, preamble, postamble or skew failure only flags the addressed location.
// - refresh decoded from select, row, column low, write high, clock enable high.
// - refresh rows come from an internal counter; banks end precharged idle.
// - self-refresh entry decoded like refresh with clock enable falling; held low after.
// - locked loop turns off at entry and back on with a reset at exit.
// - in self-refresh only clock enable and reset matter; internal clock gated. Exit here also needs a no-op or deselect command.
// - a refresh starts right at entry, then the built-in timer repeats it.
// - termination turns on and off write latency minus two link clocks after sampling.
module drs_refresh_top #(
  parameter int unsigned RFC_CYC = drs_pkg::RFC_CYC,
  parameter int unsigned REFI_CYC = drs_pkg::REFI_CYC,
  parameter int unsigned WRITE_LATENCY = drs_pkg::WRITE_LATENCY,
  parameter int unsigned ROW_W = drs_pkg::ROW_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic cke,
  input wire drs_pkg::drs_cmd_s cmd,
  input wire logic termination_control,
  input wire logic wr_timing_err,
  input wire logic [drs_pkg::ADDR_W-1:0] wr_addr,
  input wire logic dll_enable_cfg,
  output drs_pkg::drs_poison_s poison_q,
  output logic term_on_q,
  output logic refresh_pulse_q,
  output logic refresh_busy_q,
  output logic [ROW_W-1:0] refresh_row_q,
  output logic self_refresh_q,
  output logic int_clk_en_q,
  output logic dll_on_q,
  output logic dll_reset_q
);
  localparam int unsigned TERM_LAT = WRITE_LATENCY - drs_pkg::TERM_LAT_OFFSET;
  localparam int unsigned RFC_W = $clog2(RFC_CYC + 1);
  localparam int unsigned REFI_W = $clog2(REFI_CYC + 1);

  initial begin
    if (WRITE_LATENCY < drs_pkg::TERM_LAT_OFFSET + 1) $error("write latency too small");
    if (REFI_CYC <= RFC_CYC) $error("refresh interval must exceed refresh cycle time");
    if (ROW_W < 1) $error("row width must be positive");
  end

  // link domain
  logic lrst_a;
  logic lrst_n;
  logic cke_q;
  logic ref_tog_q;
  logic sre_tog_q;
  logic srx_tog_q;
  logic [TERM_LAT-1:0] odt_pipe_q;
  drs_pkg::drs_link_e lst_q;

  // reset crosses into the link domain; lrst_a only feeds lrst_n
  always_ff @(posedge link_clk) begin
    lrst_a <= nrst;
    lrst_n <= lrst_a;
  end

  wire logic ref_hit = !cmd.cs_n && !cmd.ras_n && !cmd.cas_n && cmd.we_n;
  wire logic nop_des = cmd.cs_n || (cmd.ras_n && cmd.cas_n && cmd.we_n);
  wire logic ref_cmd = (lst_q == drs_pkg::DRS_L_RUN) && cke_q && cke && ref_hit;
  wire logic sre_cmd = (lst_q == drs_pkg::DRS_L_RUN) && cke_q && !cke && ref_hit;
  wire logic srx_cmd = (lst_q == drs_pkg::DRS_L_SR) && cke && nop_des;
  // pin samples taken in self-refresh must never surface after exit
  wire logic odt_in = termination_control && (lst_q == drs_pkg::DRS_L_RUN) && !sre_cmd;

  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      cke_q <= 1'b0;
    end else begin
      cke_q <= cke;
    end
  end

  // in self-refresh only clock enable and, for exit, a no-op or deselect command are looked at
  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      lst_q <= drs_pkg::DRS_L_RUN;
      ref_tog_q <= 1'b0;
      sre_tog_q <= 1'b0;
      srx_tog_q <= 1'b0;
    end else begin
      unique case (lst_q)
        drs_pkg::DRS_L_RUN: begin
          if (ref_cmd) begin
            ref_tog_q <= !ref_tog_q;
          end
          if (sre_cmd) begin
            sre_tog_q <= !sre_tog_q;
            lst_q <= drs_pkg::DRS_L_SR;
          end
        end
        drs_pkg::DRS_L_SR: begin
          if (srx_cmd) begin
            srx_tog_q <= !srx_tog_q;
            lst_q <= drs_pkg::DRS_L_RUN;
          end
        end
        default: lst_q <= drs_pkg::DRS_L_RUN;
      endcase
    end
  end

  // termination follows the control pin by a fixed latency, never in self-refresh
  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      odt_pipe_q <= '0;
      term_on_q <= 1'b0;
    end else begin
      if (TERM_LAT > 1) begin
        odt_pipe_q <= {odt_pipe_q[TERM_LAT-2:0], odt_in};
      end else begin
        odt_pipe_q[0] <= odt_in;
      end
      term_on_q <= odt_pipe_q[TERM_LAT-1] && (lst_q == drs_pkg::DRS_L_RUN) && !sre_cmd;
    end
  end

  // a bad write only marks its own location; no state is touched, so nothing can hang
  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      poison_q <= '0;
    end else begin
      poison_q.valid <= wr_timing_err;
      poison_q.addr <= wr_timing_err ? wr_addr : poison_q.addr;
    end
  end

  a_ref_decode: assert property (@(posedge link_clk) disable iff (!lrst_n)
    ref_cmd |=> ref_tog_q != $past(ref_tog_q)) else $error("refresh not decoded");
  a_sre_decode: assert property (@(posedge link_clk) disable iff (!lrst_n)
    sre_cmd |=> lst_q == drs_pkg::DRS_L_SR && sre_tog_q != $past(sre_tog_q))
    else $error("self-refresh entry not decoded");
  a_sr_ignore: assert property (@(posedge link_clk) disable iff (!lrst_n)
    lst_q == drs_pkg::DRS_L_SR && !cke |=> $stable(ref_tog_q) && lst_q == drs_pkg::DRS_L_SR)
    else $error("command acted on in self-refresh");
  a_term_latency: assert property (@(posedge link_clk) disable iff (!lrst_n)
    term_on_q |-> $past(termination_control, TERM_LAT + 1)) else $error("termination latency wrong");
  a_term_sr_off: assert property (@(posedge link_clk) disable iff (!lrst_n)
    lst_q == drs_pkg::DRS_L_SR |-> !term_on_q) else $error("termination on in self-refresh");
  a_poison_addr: assert property (@(posedge link_clk) disable iff (!lrst_n)
    wr_timing_err |=> poison_q.valid && poison_q.addr == $past(wr_addr))
    else $error("bad write not flagged at its address");
  a_poison_only: assert property (@(posedge link_clk) disable iff (!lrst_n)
    !wr_timing_err |=> !poison_q.valid && $stable(poison_q.addr)) else $error("spurious corruption flag");

  // core domain
  logic ref_p;
  logic sre_p;
  logic srx_p;
  logic [RFC_W-1:0] rfc_cnt_q;
  logic [REFI_W-1:0] sr_cnt_q;
  drs_pkg::drs_core_e cst_q;

  drs_tog_sync u_ref_sync (.dst_clk(clk), .dst_rst_n(nrst), .tog_in(ref_tog_q), .pulse_out(ref_p));
  drs_tog_sync u_sre_sync (.dst_clk(clk), .dst_rst_n(nrst), .tog_in(sre_tog_q), .pulse_out(sre_p));
  drs_tog_sync u_srx_sync (.dst_clk(clk), .dst_rst_n(nrst), .tog_in(srx_tog_q), .pulse_out(srx_p));

  // timer ticks on the first cycle of self-refresh, well inside the minimum pulse time
  wire logic sr_tick = (cst_q == drs_pkg::DRS_C_SR) && (sr_cnt_q == '0);
  wire logic ref_go = ref_p || sr_tick;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cst_q <= drs_pkg::DRS_C_NORM;
      sr_cnt_q <= '0;
    end else begin
      unique case (cst_q)
        drs_pkg::DRS_C_NORM: begin
          sr_cnt_q <= '0;
          if (sre_p) begin
            cst_q <= drs_pkg::DRS_C_SR;
          end
        end
        drs_pkg::DRS_C_SR: begin
          if (sr_cnt_q == REFI_W'(REFI_CYC - 1)) begin
            sr_cnt_q <= '0;
          end else begin
            sr_cnt_q <= sr_cnt_q + 1'b1;
          end
          if (srx_p) begin
            cst_q <= drs_pkg::DRS_C_NORM;
          end
        end
        default: cst_q <= drs_pkg::DRS_C_NORM;
      endcase
    end
  end

  // the row address never looks at the address pins
  always_ff @(posedge clk) begin
    if (!nrst) begin
      refresh_row_q <= '0;
      rfc_cnt_q <= '0;
      refresh_pulse_q <= 1'b0;
      refresh_busy_q <= 1'b0;
    end else begin
      refresh_pulse_q <= ref_go;
      if (ref_go) begin
        refresh_row_q <= refresh_row_q + 1'b1;
        rfc_cnt_q <= RFC_W'(RFC_CYC - 1);
        refresh_busy_q <= 1'b1;
      end else if (rfc_cnt_q != '0) begin
        rfc_cnt_q <= rfc_cnt_q - 1'b1;
      end else begin
        refresh_busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      self_refresh_q <= 1'b0;
      int_clk_en_q <= 1'b1;
      dll_on_q <= 1'b0;
      dll_reset_q <= 1'b0;
    end else begin
      self_refresh_q <= (cst_q == drs_pkg::DRS_C_NORM) ? sre_p : !srx_p;
      int_clk_en_q <= (cst_q == drs_pkg::DRS_C_NORM) ? !sre_p : srx_p;
      dll_reset_q <= (cst_q == drs_pkg::DRS_C_SR) && srx_p && dll_enable_cfg;
      if (cst_q == drs_pkg::DRS_C_NORM) begin
        dll_on_q <= dll_enable_cfg && !sre_p;
      end else begin
        dll_on_q <= srx_p && dll_enable_cfg;
      end
    end
  end

  a_sr_first_ref: assert property (@(posedge clk) disable iff (!nrst)
    cst_q == drs_pkg::DRS_C_NORM && sre_p |-> ##[1:2] refresh_pulse_q)
    else $error("no refresh at self-refresh entry");
  a_row_advance: assert property (@(posedge clk) disable iff (!nrst)
    ref_go |=> refresh_row_q == $past(refresh_row_q) + 1'b1 && refresh_busy_q)
    else $error("refresh row not advanced");
  a_dll_entry: assert property (@(posedge clk) disable iff (!nrst)
    cst_q == drs_pkg::DRS_C_NORM && sre_p |=> !dll_on_q && self_refresh_q)
    else $error("loop left on in self-refresh");
  a_dll_exit: assert property (@(posedge clk) disable iff (!nrst)
    cst_q == drs_pkg::DRS_C_SR && srx_p && dll_enable_cfg |=> dll_reset_q && dll_on_q ##1 !dll_reset_q)
    else $error("loop not restarted at exit");
  a_clk_gate: assert property (@(posedge clk) disable iff (!nrst)
    self_refresh_q |-> !int_clk_en_q && !dll_on_q) else $error("internal clock running in self-refresh");
endmodule // drs_refresh_top

// [drs_refresh_top_tb.sv]
// self-checking bench for the refresh and self-refresh block
// assumes the controller model drives every link-side input; timer shortened to 8 core cycles
`timescale 1ns/1ps
module drs_refresh_top_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic dll_enable_cfg = 1'b1;
  logic link_clk, cke, termination_control, wr_timing_err;
  drs_pkg::drs_cmd_s cmd;
  logic [drs_pkg::ADDR_W-1:0] wr_addr;
  drs_pkg::drs_poison_s poison_q;
  logic term_on_q, refresh_pulse_q, refresh_busy_q, self_refresh_q, int_clk_en_q, dll_on_q, dll_reset_q;
  logic [drs_pkg::ROW_W-1:0] refresh_row_q;
  logic [15:0] npulse = 16'h0;
  int err_count = 0;
  int num_checks = 0;
  always #25 clk = ~clk;
  always @(posedge clk) if (refresh_pulse_q === 1'b1) npulse <= npulse + 16'h1;
  drs_ctrl_model ctl (.link_clk(link_clk), .cke(cke), .cmd(cmd), .termination_control(termination_control),
    .wr_timing_err(wr_timing_err), .wr_addr(wr_addr));
  drs_refresh_top #(.REFI_CYC(8)) DUT (.clk(clk), .nrst(nrst), .link_clk(link_clk), .cke(cke), .cmd(cmd),
    .termination_control(termination_control), .wr_timing_err(wr_timing_err), .wr_addr(wr_addr),
    .dll_enable_cfg(dll_enable_cfg), .poison_q(poison_q), .term_on_q(term_on_q), .refresh_pulse_q(refresh_pulse_q),
    .refresh_busy_q(refresh_busy_q), .refresh_row_q(refresh_row_q), .self_refresh_q(self_refresh_q),
    .int_clk_en_q(int_clk_en_q), .dll_on_q(dll_on_q), .dll_reset_q(dll_reset_q));
  task check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // bounded wait for the pulse count to reach n
  task wait_pulses(input logic [15:0] n);
    int i;
    for (i = 0; i < 40 && npulse < n; i++) @(posedge clk);
    #1;
    check(npulse, n);
    check({2'h0, refresh_row_q}, npulse);
  endtask
  task test_refresh;
    // banks never opened; a handful of refreshes stays far inside eight credits
    ctl.send(1'b1, 4'b0001, 1'b0);
    ctl.send(1'b1, 4'b0111, 1'b0);
    wait_pulses(16'h1);
    check({15'h0, refresh_busy_q}, 16'h1);
    // activate pattern must not start a refresh
    ctl.send(1'b1, 4'b0011, 1'b0);
    ctl.send(1'b1, 4'b0111, 1'b0);
    repeat (20) @(posedge clk);
    #1;
    check(npulse, 16'h1);
    check({15'h0, refresh_busy_q}, 16'h0);
  endtask
  task test_poison;
    ctl.werr(14'h2a5);
    check({1'b0, poison_q}, {2'h1, 14'h2a5});
    @(posedge link_clk);
    #1;
    check({15'h0, poison_q.valid}, 16'h0);
    check(npulse, 16'h1);
  endtask
  task test_term;
    ctl.send(1'b1, 4'b0111, 1'b1);
    ctl.send(1'b1, 4'b0111, 1'b0);
    @(posedge link_clk);
    #1;
    check({15'h0, term_on_q}, 16'h0);
    @(posedge link_clk);
    #1;
    check({15'h0, term_on_q}, 16'h0);
    @(posedge link_clk);
    #1;
    check({15'h0, term_on_q}, 16'h1);
    @(posedge link_clk);
    #1;
    check({15'h0, term_on_q}, 16'h0);
  endtask
  task test_self_refresh;
    int i;
    logic [15:0] n0;
    repeat (8) @(posedge link_clk);
    ctl.send(1'b0, 4'b0001, 1'b0);
    // junk while in self-refresh, termination requested too
    ctl.send(1'b0, 4'b0001, 1'b1);
    for (i = 0; i < 20 && self_refresh_q !== 1'b1; i++) @(posedge clk);
    #1;
    n0 = npulse;
    check({self_refresh_q, int_clk_en_q, dll_on_q}, 16'h4);
    ctl.set_run(1'b0);
    repeat (41) @(posedge clk);
    #1;
    check(npulse - n0, 16'h6);
    check({2'h0, refresh_row_q}, npulse);
    check({15'h0, term_on_q}, 16'h0);
    ctl.set_run(1'b1);
    ctl.send(1'b0, 4'b0111, 1'b0);
    ctl.send(1'b1, 4'b0111, 1'b0);
    // look right after each edge: the loop reset pulse stands one cycle only
    for (i = 0; i < 20 && self_refresh_q !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    check({self_refresh_q, int_clk_en_q, dll_on_q, dll_reset_q}, 16'h7);
    @(posedge clk);
    #1;
    check({15'h0, dll_reset_q}, 16'h0);
    n0 = npulse;
    repeat (30) @(posedge clk);
    #1;
    check(npulse, n0);
    // second round with the locked loop disabled: no loop restart at exit
    dll_enable_cfg = 1'b0;
    ctl.send(1'b1, 4'b0001, 1'b0);
    ctl.send(1'b1, 4'b0111, 1'b0);
    wait_pulses(n0 + 16'h1);
    check({15'h0, dll_on_q}, 16'h0);
    repeat (4) @(posedge link_clk);
    ctl.send(1'b0, 4'b0001, 1'b0);
    ctl.send(1'b0, 4'b0111, 1'b0);
    for (i = 0; i < 20 && self_refresh_q !== 1'b1; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    ctl.send(1'b1, 4'b0111, 1'b0);
    for (i = 0; i < 20 && self_refresh_q !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    check({self_refresh_q, int_clk_en_q, dll_on_q, dll_reset_q}, 16'h4);
  endtask
  initial begin
    #500000;
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    #1;
    check({poison_q, term_on_q}, 16'h0);
    check({refresh_busy_q, self_refresh_q, int_clk_en_q, dll_reset_q}, 16'h2);
    check({2'h0, refresh_row_q}, 16'h0);
    nrst = 1'b1;
    repeat (10) @(posedge clk);
    test_refresh();
    test_poison();
    test_term();
    test_self_refresh();
    end_of_test();
  end
endmodule // drs_refresh_top_tb

// [drs_tog_sync.sv]
// toggle event crossing into the destination clock domain
// assumes the source flips tog_in once per event, slower than three destination edges
`timescale 1ns/1ps
module drs_tog_sync (
  input wire logic dst_clk,
  input wire logic dst_rst_n,
  input wire logic tog_in,
  output logic pulse_out
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // meta_q feeds sync_q only
  always_ff @(posedge dst_clk) begin
    meta_q <= tog_in;
    sync_q <= meta_q;
  end

  always_ff @(posedge dst_clk) begin
    if (!dst_rst_n) begin
      last_q <= 1'b0;
      pulse_out <= 1'b0;
    end else begin
      last_q <= sync_q;
      pulse_out <= sync_q ^ last_q;
    end
  end
endmodule // drs_tog_sync
